/* hw/sfwp_defines.vh */
// Purpose: Shared constants of the serial flash command front end.
// Assumes: 200 MHz system clock; cycle counts are defaults only.
// Notes:   Included by every design file of the block.
`ifndef SFWP_DEFINES_VH
`define SFWP_DEFINES_VH

// Command codes
`define SFWP_CMD_WRITE_ENABLE  8'h06
`define SFWP_CMD_WRITE_DISABLE 8'h04
`define SFWP_CMD_STATUS_WRITE  8'h01
`define SFWP_CMD_STATUS_READ   8'h05
`define SFWP_CMD_PAGE_PROGRAM  8'h02
`define SFWP_CMD_SECTOR_ERASE  8'hd8
`define SFWP_CMD_BULK_ERASE    8'hc7

// Status byte field positions
`define SFWP_ST_BUSY   0
`define SFWP_ST_WEL    1
`define SFWP_ST_BP_LO  2
`define SFWP_ST_BP_HI  4
`define SFWP_ST_LOCK   7

// Operations handed to the array back end, erased byte value and word width
`define SFWP_OP_PROGRAM 2'h0
`define SFWP_OP_SECTOR  2'h1
`define SFWP_OP_BULK    2'h2
`define SFWP_ERASED     8'hff
`define SFWP_WORD_W     34

// Command geometry
`define SFWP_HDR_BYTES  3'h4
`define SFWP_PAGE_BYTES 9'h100
`define SFWP_ALL_SECT   8'h80

// Power-up delay and internal cycle lengths in system clocks (defaults of top parameters)
`define SFWP_T_PUW_CYC  32'h0000_2000
`define SFWP_T_SW_CYC   32'h0000_3000
`define SFWP_T_PROG_CYC 32'h0000_4000
`define SFWP_T_SE_CYC   32'h0000_8000
`define SFWP_T_BE_CYC   32'h0001_0000

`endif

/* hw/sfwp_buf2.v */
// Purpose: Two-entry valid/ready buffer in the array word path.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Head is always slot 0; outputs and in_ready come from flops.
`timescale 1ns/1ps
`include "sfwp_defines.vh"

module sfwp_buf2 (
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    nrst_in,
  // Fill side
  input  wire                    in_valid_in,
  output reg                     in_ready_out,
  input  wire [`SFWP_WORD_W-1:0] in_data_in,
  // Drain side
  output reg                     out_valid_out,
  input  wire                    out_ready_in,
  output reg  [`SFWP_WORD_W-1:0] out_data_out
);

  reg [`SFWP_WORD_W-1:0] slot1_q;
  reg                    v1_q;
  wire                   push;
  wire                   pop;

  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  ////////////////////////////////////////////////////////////////////////
  // Shift structure: a stalled drain fills slot 1 and drops in_ready
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      out_valid_out <= 1'b0;
      v1_q          <= 1'b0;
      in_ready_out  <= 1'b1;
      out_data_out  <= {`SFWP_WORD_W{1'b0}};
      slot1_q       <= {`SFWP_WORD_W{1'b0}};
    end else begin
      if (pop) begin
        out_valid_out <= v1_q | push;
        out_data_out  <= v1_q ? slot1_q : in_data_in;
        v1_q          <= v1_q & push;
        slot1_q       <= in_data_in;
        in_ready_out  <= 1'b1;
      end else if (push) begin
        if (out_valid_out) begin
          slot1_q      <= in_data_in;
          v1_q         <= 1'b1;
          in_ready_out <= 1'b0;   // Both slots now held
        end else begin
          out_data_out  <= in_data_in;
          out_valid_out <= 1'b1;
        end
      end
    end
  end

endmodule

/* hw/sfwp_seq.v */
// Purpose: Serial flash front end: serial command decode, write latch,
//          protection, hold handling and internal cycle sequencing.
// Assumes: All pins asynchronous to CLK_IN; serial clock well below CLK_IN/4.
// Notes:   Array words leave through a two-entry buffer to a back end.
// Notes on behaviour
// - Bits taken on serial clock rise, output changes on its fall; both idle levels.
// - Page program writes 1 to 256 bytes wrapping inside one page.
// - Write enable first, then command, three address bytes, data, then cycle.
// - Program only clears bits; erase leaves every byte at FFh.
// - Sector erase one sector, bulk erase all, each after write enable.
// - Busy flag set while status write, program or erase runs.
// - Boost level on BOOST_IN selects fast program and erase.
// - Stay active after deselect until cycle ends; select makes active.
// - Modifying commands run only when clock count is a multiple of eight.
// - Modifying commands need the write enable latch set.
// - Latch cleared at reset and by disable, status write, program, erases.
// - Reset and power-up timer inhibit modifying operations.
// - Three protect bits lock the upper 0,2,4..64 or all 128 sectors.
// - Protect pin low freezes protect bits and status lock bit.
// - Bulk erase runs only when all protect bits are zero.
// - Hold starts at pause fall with clock low, else at next clock low.
// - Hold ends at pause rise with clock low, else at next clock low.
// - In hold the output floats, inputs ignored, interface state kept.
// - Hold never aborts an internal cycle.
// - Deselect during hold resets the interface; resume with pause high then select.
// - Output floats when deselected; a select fall is needed after power-up.
// - Bytes travel most significant bit first, command byte first.
`timescale 1ns/1ps
`include "sfwp_defines.vh"

module sfwp_seq #(
  parameter [31:0] T_PUW  = `SFWP_T_PUW_CYC,
  parameter [31:0] T_SW   = `SFWP_T_SW_CYC,
  parameter [31:0] T_PROG = `SFWP_T_PROG_CYC,
  parameter [31:0] T_SE   = `SFWP_T_SE_CYC,
  parameter [31:0] T_BE   = `SFWP_T_BE_CYC
) (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        NRST_IN,
  // Serial pins
  input  wire        SCK_IN,
  input  wire        SDI_IN,
  input  wire        NCS_IN,
  input  wire        NHOLD_IN,
  input  wire        NWP_IN,
  input  wire        BOOST_IN,
  output reg         SDO_OUT,
  output reg         SDO_OE_OUT,
  // Array word stream
  output wire        MEM_VALID_OUT,
  input  wire        MEM_READY_IN,
  output wire [1:0]  MEM_OP_OUT,
  output wire [22:0] MEM_ADDR_OUT,
  output wire [7:0]  MEM_DATA_OUT,
  output wire        MEM_FAST_OUT,
  // Status
  output reg         BUSY_OUT,
  output reg         WEL_OUT,
  output reg  [2:0]  PROTECT_OUT,
  output reg         LOCK_OUT,
  output reg         ACTIVE_OUT,
  output reg         READY_OUT
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EMIT = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  // Sector lies inside the protected top area
  function prot_hit;
    input [6:0] sect;
    input [2:0] bp;
    reg   [7:0] span;
    begin
      span     = (bp == 3'h0) ? 8'h00 : (8'h01 << bp);
      prot_hit = ({1'b0, sect} + span) >= `SFWP_ALL_SECT;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: order sck, sdi, ncs, nhold, nwp, boost
  reg  [5:0] s1_q;
  reg  [5:0] s2_q;
  reg        sck_d1_q;
  reg        ncs_d1_q;
  wire       sck_s  = s2_q[5];
  wire       sdi_s  = s2_q[4];
  wire       ncs_s  = s2_q[3];
  wire       hold_n = s2_q[2];
  wire       nwp_s  = s2_q[1];
  wire       boost  = s2_q[0];
  wire       sck_rise = sck_s & ~sck_d1_q;
  wire       sck_fall = ~sck_s & sck_d1_q;
  wire       cs_fall  = ~ncs_s & ncs_d1_q;
  wire       cs_rise  = ncs_s & ~ncs_d1_q;

  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      s1_q     <= 6'h2e;   // Idle: clock high, deselected, no pause, no boost
      s2_q     <= 6'h2e;
      sck_d1_q <= 1'b0;
      ncs_d1_q <= 1'b1;
    end else begin
      s1_q     <= {SCK_IN, SDI_IN, NCS_IN, NHOLD_IN, NWP_IN, BOOST_IN};
      s2_q     <= s1_q;
      sck_d1_q <= sck_s;
      ncs_d1_q <= ncs_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interface state
  reg        sel_q;
  reg        hold_q;
  reg        armed_q;
  reg  [2:0] bit_q;
  reg  [2:0] hdr_q;
  reg  [8:0] dcnt_q;
  reg  [7:0] sh_q;
  reg  [7:0] cmd_q;
  reg  [22:0] addr_q;
  reg  [7:0] sw_q;
  reg  [7:0] tx_q;
  reg        rd_q;
  reg  [7:0] page_mem [0:255];
  reg  [31:0] puw_q;
  reg        start_q;
  reg  [1:0] sop_q;
  reg  [2:0] state_q;
  wire [7:0] byte_in = {sh_q[6:0], sdi_s};
  wire [7:0] status  = {LOCK_OUT, 2'h0, PROTECT_OUT, WEL_OUT, BUSY_OUT};
  wire       can_mod = READY_OUT & armed_q & (bit_q == 3'h0) & ~BUSY_OUT;
  wire       sect_ok = ~prot_hit(addr_q[22:16], PROTECT_OUT);

  // Hold tracks pause only while the clock is low
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      hold_q <= 1'b0;
    end else if (~sel_q | cs_rise) begin
      hold_q <= 1'b0;
    end else if (~sck_s) begin
      hold_q <= ~hold_n;
    end
  end

  // Power-up write inhibit timer
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      puw_q     <= 32'h0000_0000;
      READY_OUT <= 1'b0;
    end else if (puw_q != T_PUW) begin
      puw_q <= puw_q + 32'h0000_0001;
    end else begin
      READY_OUT <= 1'b1;
    end
  end

  // Page bytes land at wrapping offsets inside the addressed page
  always @(posedge CLK_IN) begin
    if (sel_q & ~hold_q & sck_rise & (bit_q == 3'h7) && (hdr_q == `SFWP_HDR_BYTES) &&
        (cmd_q == `SFWP_CMD_PAGE_PROGRAM)) begin
      page_mem[addr_q[7:0] + dcnt_q[7:0]] <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial shifting, decode at deselect, latch and status bits
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      sel_q       <= 1'b0;
      armed_q     <= 1'b0;
      bit_q       <= 3'h0;
      hdr_q       <= 3'h0;
      dcnt_q      <= 9'h000;
      sh_q        <= 8'h00;
      cmd_q       <= 8'h00;
      addr_q      <= 23'h000000;
      sw_q        <= 8'h00;
      tx_q        <= 8'h00;
      rd_q        <= 1'b0;
      WEL_OUT     <= 1'b0;
      PROTECT_OUT <= 3'h0;
      LOCK_OUT    <= 1'b0;
      start_q     <= 1'b0;
      sop_q       <= `SFWP_OP_PROGRAM;
      SDO_OUT     <= 1'b0;
      SDO_OE_OUT  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (cs_fall) begin
        sel_q   <= 1'b1;
        armed_q <= 1'b1;
        bit_q   <= 3'h0;
        hdr_q   <= 3'h0;
        dcnt_q  <= 9'h000;
        rd_q    <= 1'b0;
      end else if (cs_rise) begin
        sel_q <= 1'b0;
        rd_q  <= 1'b0;
        // A deselect while paused resets the interface without executing
        if (sel_q & ~hold_q & can_mod) begin
          case (cmd_q)
            `SFWP_CMD_WRITE_ENABLE: begin
              if (hdr_q == 3'h1) WEL_OUT <= 1'b1;
            end
            `SFWP_CMD_WRITE_DISABLE: begin
              if (hdr_q == 3'h1) WEL_OUT <= 1'b0;
            end
            `SFWP_CMD_STATUS_WRITE: begin
              if (WEL_OUT & (hdr_q >= 3'h2)) begin
                WEL_OUT <= 1'b0;
                if (nwp_s) begin
                  PROTECT_OUT <= sw_q[`SFWP_ST_BP_HI:`SFWP_ST_BP_LO];
                  LOCK_OUT    <= sw_q[`SFWP_ST_LOCK];
                end
                start_q <= 1'b1;
                sop_q   <= 2'h3;                     // Status cycle, no array word
              end
            end
            `SFWP_CMD_PAGE_PROGRAM: begin
              if (WEL_OUT & (dcnt_q != 9'h000)) begin
                WEL_OUT <= 1'b0;
                start_q <= sect_ok;
                sop_q   <= `SFWP_OP_PROGRAM;
              end
            end
            `SFWP_CMD_SECTOR_ERASE: begin
              if (WEL_OUT & (hdr_q == `SFWP_HDR_BYTES) & (dcnt_q == 9'h000)) begin
                WEL_OUT <= 1'b0;
                start_q <= sect_ok;
                sop_q   <= `SFWP_OP_SECTOR;
              end
            end
            `SFWP_CMD_BULK_ERASE: begin
              if (WEL_OUT & (hdr_q == 3'h1)) begin
                WEL_OUT <= 1'b0;
                start_q <= (PROTECT_OUT == 3'h0);
                sop_q   <= `SFWP_OP_BULK;
              end
            end
            default: begin
            end
          endcase
        end
      end else if (sel_q & ~hold_q) begin
        if (sck_rise) begin
          sh_q  <= byte_in;
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            if (hdr_q == 3'h0) begin
              cmd_q <= byte_in;
              rd_q  <= (byte_in == `SFWP_CMD_STATUS_READ);
            end else if (hdr_q < `SFWP_HDR_BYTES) begin
              addr_q <= {addr_q[14:0], byte_in};
              sw_q   <= byte_in;
            end else if (dcnt_q != `SFWP_PAGE_BYTES) begin
              dcnt_q <= dcnt_q + 9'h001;      // Extra bytes all overwrite the first byte's slot
            end
            if (hdr_q != `SFWP_HDR_BYTES) hdr_q <= hdr_q + 3'h1;
            // Status is resampled every byte so polling sees busy fall
            tx_q <= status;
          end
        end else if (sck_fall & rd_q) begin
          SDO_OUT <= tx_q[7];
          tx_q    <= {tx_q[6:0], 1'b0};
        end
      end
      SDO_OE_OUT <= sel_q & ~cs_rise & ~hold_q & rd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal cycle: emit array words, then time the cycle
  reg  [31:0] tmr_q;
  reg  [8:0]  en_q;
  reg  [8:0]  ei_q;
  reg  [1:0]  eop_q;
  reg  [22:0] eaddr_q;
  reg         fast_q;
  reg         push_q;
  wire        buf_ready;
  wire [7:0]  eoff = eaddr_q[7:0] + ei_q[7:0];
  wire [7:0]  edat = (eop_q == `SFWP_OP_PROGRAM) ? page_mem[eoff] : `SFWP_ERASED;
  wire [31:0] tsel = (sop_q == `SFWP_OP_PROGRAM) ? T_PROG :
                     (sop_q == `SFWP_OP_SECTOR)  ? T_SE   :
                     (sop_q == `SFWP_OP_BULK)    ? T_BE   : T_SW;

  always @*
    push_q = (state_q == ST_EMIT);

  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      state_q <= ST_IDLE;
      tmr_q   <= 32'h0000_0000;
      en_q    <= 9'h000;
      ei_q    <= 9'h000;
      eop_q   <= `SFWP_OP_PROGRAM;
      eaddr_q <= 23'h000000;
      fast_q  <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            BUSY_OUT <= 1'b1;
            fast_q   <= boost & (sop_q != 2'h3);
            tmr_q    <= (boost & (sop_q != 2'h3)) ? {1'b0, tsel[31:1]} : tsel;
            eop_q    <= sop_q;
            eaddr_q  <= addr_q;
            ei_q     <= 9'h000;
            en_q     <= (sop_q == `SFWP_OP_PROGRAM) ? dcnt_q : 9'h001;
            state_q  <= (sop_q == 2'h3) ? ST_WAIT : ST_EMIT;
          end
        end
        ST_EMIT: begin
          // A stalled back end holds the cycle here; busy stays up
          if (buf_ready) begin
            ei_q <= ei_q + 9'h001;
            if (ei_q + 9'h001 == en_q) state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Runs regardless of hold or select; busy also waits for the buffer to drain
          if (tmr_q != 32'h0000_0000) begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end else if (~MEM_VALID_OUT) begin
            BUSY_OUT <= 1'b0;
            state_q  <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Active while selected or while an internal cycle still runs
  always @(posedge CLK_IN) begin
    if (!NRST_IN) ACTIVE_OUT <= 1'b0;
    else ACTIVE_OUT <= ~ncs_s | BUSY_OUT | start_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Word buffer toward the array back end
  wire [`SFWP_WORD_W-1:0] buf_out;
  wire [22:0] waddr = (eop_q == `SFWP_OP_PROGRAM) ? {eaddr_q[22:8], eoff} : eaddr_q;

  sfwp_buf2 u_buf (
    .clk_in        (CLK_IN),
    .nrst_in       (NRST_IN),
    .in_valid_in   (push_q),
    .in_ready_out  (buf_ready),
    .in_data_in    ({fast_q, eop_q, waddr, edat}),
    .out_valid_out (MEM_VALID_OUT),
    .out_ready_in  (MEM_READY_IN),
    .out_data_out  (buf_out)
  );

  assign MEM_FAST_OUT = buf_out[33];
  assign MEM_OP_OUT   = buf_out[32:31];
  assign MEM_ADDR_OUT = buf_out[30:8];
  assign MEM_DATA_OUT = buf_out[7:0];

endmodule

/* tb/sfwp_seq_sva.sv */
// Purpose: Port-level assertions on the flash command front end.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Attached to every sfwp_seq instance by the bind at the foot.
`timescale 1ns/1ps
module sfwp_seq_sva (
  // Clock, reset, select and back end ready
  input wire        CLK_IN,
  input wire        NRST_IN,
  input wire        NCS_IN,
  input wire        MEM_READY_IN,
  // Observed outputs
  input wire        SDO_OE_OUT,
  input wire        MEM_VALID_OUT,
  input wire [1:0]  MEM_OP_OUT,
  input wire [22:0] MEM_ADDR_OUT,
  input wire [7:0]  MEM_DATA_OUT,
  input wire        BUSY_OUT,
  input wire        WEL_OUT,
  input wire [2:0]  PROTECT_OUT,
  input wire        ACTIVE_OUT,
  input wire        READY_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  ////////////////////////////////////////////////////////////////////////////
  // Pin and power mode relations; four cycles cover the pin synchronisers
  property p_oe_idle; NCS_IN [*4] |-> !SDO_OE_OUT; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
  property p_active_sel; !NCS_IN [*5] |-> ACTIVE_OUT; endproperty
  a_active_sel: assert property (p_active_sel) else $error("selected but not active");
  property p_active_busy; BUSY_OUT |-> ACTIVE_OUT; endproperty
  a_active_busy: assert property (p_active_busy) else $error("standby during a cycle");
  property p_ready_gate; !READY_OUT |-> !BUSY_OUT; endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("cycle before power-up delay");
  // Word stream relations
  property p_valid_busy; MEM_VALID_OUT |-> BUSY_OUT; endproperty
  a_valid_busy: assert property (p_valid_busy) else $error("word sent while not busy");
  property p_stall;
    MEM_VALID_OUT && !MEM_READY_IN |=> MEM_VALID_OUT && $stable({MEM_OP_OUT, MEM_ADDR_OUT, MEM_DATA_OUT});
  endproperty
  a_stall: assert property (p_stall) else $error("word changed while stalled");
  property p_erase_ff; MEM_VALID_OUT && MEM_OP_OUT != 2'h0 |-> MEM_DATA_OUT == 8'hff; endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("erase word not all ones");
  property p_bulk_bp; MEM_VALID_OUT && MEM_OP_OUT == 2'h2 |-> PROTECT_OUT == 3'h0; endproperty
  a_bulk_bp: assert property (p_bulk_bp) else $error("bulk erase with protection set");
  property p_sect_bp;
    MEM_VALID_OUT && MEM_OP_OUT != 2'h2 && PROTECT_OUT != 3'h0
      |-> {1'b0, MEM_ADDR_OUT[22:16]} < 8'h80 - (8'h01 << PROTECT_OUT);
  endproperty
  a_sect_bp: assert property (p_sect_bp) else $error("write into protected sector");
  // Latch relations; the latch is gone within two clocks of a cycle start
  property p_wel_clear; $rose(BUSY_OUT) |-> ##[0:2] !WEL_OUT; endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch kept after command");
  property p_wel_busy; $rose(WEL_OUT) |-> !$past(BUSY_OUT); endproperty
  a_wel_busy: assert property (p_wel_busy) else $error("latch set during a cycle");
endmodule

bind sfwp_seq sfwp_seq_sva u_sva (.CLK_IN, .NRST_IN, .NCS_IN, .MEM_READY_IN, .SDO_OE_OUT, .MEM_VALID_OUT,
  .MEM_OP_OUT, .MEM_ADDR_OUT, .MEM_DATA_OUT, .BUSY_OUT, .WEL_OUT, .PROTECT_OUT, .ACTIVE_OUT, .READY_OUT);

/* tb/sfwp_master.sv */
// Purpose: Serial link master driving framed transfers into the device.
// Assumes: Link clock of 80 ns made from 8 system clocks per half.
// Notes:   Clock stands at its idle level between frames.
`timescale 1ns/1ps
module sfwp_master (
  // Pacing clock
  input  wire  clk_in,
  // Serial pins
  output logic sck_out,
  output logic sdi_out,
  output logic ncs_out,
  output logic nhold_out,
  input  wire  sdo_in,
  input  wire  sdo_oe_in
);
  logic [7:0] tx [0:7];
  logic [7:0] rx;
  logic       cpol;
  int         brk;
  int         pz;
  logic       hold_oe;
  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    ncs_out = 1'b1;
    nhold_out = 1'b1;
    cpol = 1'b0;
    brk = -1;
    pz = -1;
    hold_oe = 1'b1;
    rx = 8'h00;
  end
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  // Mode change parks the clock at the new idle level while deselected
  task automatic set_mode(input logic p);
    cpol = p;
    sck_out = p;
  endtask
  // One frame; a bit index equal to brk pauses, deselects and ends it
  task automatic frame(input int nbits);
    int i;
    ncs_out = 1'b0;
    half();
    for (i = 0; i < nbits; i++) begin
      if (i == brk) begin
        nhold_out = 1'b0;
        half();
        sck_out = cpol;
        half();
        ncs_out = 1'b1;
        half();
        nhold_out = 1'b1;
        half();
        return;
      end
      sck_out = 1'b0;
      sdi_out = tx[i / 8][7 - i % 8];
      // Pause with the clock low; the pulse and data flip inside must be ignored
      if (i == pz) begin
        nhold_out = 1'b0;
        half();
        hold_oe = sdo_oe_in;
        sck_out = 1'b1;
        sdi_out = ~sdi_out;
        half();
        sck_out = 1'b0;
        sdi_out = ~sdi_out;
        half();
        nhold_out = 1'b1;
        half();
      end
      half();
      sck_out = 1'b1;
      rx = {rx[6:0], sdo_oe_in ? sdo_in : ~rx[0]};
      half();
    end
    sck_out = cpol;
    half();
    ncs_out = 1'b1;
    sdi_out = ~sdi_out;
    half();
  endtask
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench of the flash command front end.
// Assumes: Short cycle parameters; bench drives inputs on the falling edge.
// Notes:   Words leaving the buffer are queued and compared afterwards.
`timescale 1ns/1ps
`include "sfwp_defines.vh"
module tb_top;
  logic        clk;
  logic        nrst;
  logic        nwp;
  logic        boost;
  logic        mem_ready;
  wire         sck, sdi, ncs, nhold, sdo, sdo_oe, mem_valid, mem_fast, busy, write_enable_latch, lock, active, ready;
  wire  [1:0]  mem_op;
  wire  [22:0] mem_addr;
  wire  [7:0]  mem_data;
  wire  [2:0]  protect;
  logic [33:0] wq [$];
  logic [33:0] w;
  int          n_fail;
  int          samples_checked;
  sfwp_seq #(.T_PUW(32'h10), .T_SW(32'h20), .T_PROG(32'h20), .T_SE(32'h20), .T_BE(32'h30)) dut (
    .CLK_IN(clk), .NRST_IN(nrst), .SCK_IN(sck), .SDI_IN(sdi), .NCS_IN(ncs), .NHOLD_IN(nhold), .NWP_IN(nwp),
    .BOOST_IN(boost), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .MEM_VALID_OUT(mem_valid), .MEM_READY_IN(mem_ready),
    .MEM_OP_OUT(mem_op), .MEM_ADDR_OUT(mem_addr), .MEM_DATA_OUT(mem_data), .MEM_FAST_OUT(mem_fast),
    .BUSY_OUT(busy), .WEL_OUT(write_enable_latch), .PROTECT_OUT(protect), .LOCK_OUT(lock), .ACTIVE_OUT(active),
    .READY_OUT(ready));
  sfwp_master m (.clk_in(clk), .sck_out(sck), .sdi_out(sdi), .ncs_out(ncs), .nhold_out(nhold),
    .sdo_in(sdo), .sdo_oe_in(sdo_oe));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock and the back end's word log
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (mem_valid && mem_ready) wq.push_back({mem_fast, mem_op, mem_addr, mem_data});
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [55:0] v, input int nbits);
    for (int i = 0; i < 7; i++) m.tx[i] = v[55 - 8 * i -: 8];
    m.frame(nbits);
  endtask
  task automatic write_enable_cmd();
    send({`SFWP_CMD_WRITE_ENABLE, 48'h0}, 8);
  endtask
  // Status read; the second byte lands in the master's receive register
  task automatic st(input logic [7:0] e);
    send({`SFWP_CMD_STATUS_READ, 48'h0}, 16);
    chk({26'h0, m.rx}, {26'h0, e});
  endtask
  // Busy polling, bounded so a stuck cycle counts as a failure
  task automatic poll();
    for (int k = 0; k < 100; k++) begin
      send({`SFWP_CMD_STATUS_READ, 48'h0}, 16);
      if (m.rx[0] === 1'b0) return;
    end
    chk(34'h1, 34'h0);
  endtask
  task automatic conclude();
    $display("counts: checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run of some 10k clocks
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    nwp = 1'b1;
    boost = 1'b0;
    mem_ready = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    chk({write_enable_latch, busy, protect, ready}, 34'h0);
    repeat (40) @(negedge clk);
    chk(ready, 34'h1);
    $display("test power_up done");
    write_enable_cmd();
    st(8'h02);
    send({`SFWP_CMD_WRITE_DISABLE, 48'h0}, 8);
    st(8'h00);
    send({`SFWP_CMD_PAGE_PROGRAM, 24'h000010, 8'h55, 16'h0}, 40);
    chk(busy, 34'h0);
    $display("test latch done");
    // Mode 3 program across the page end while the back end stalls
    m.set_mode(1'b1);
    write_enable_cmd();
    mem_ready = 1'b0;
    send({`SFWP_CMD_PAGE_PROGRAM, 24'h0012fe, 24'h5a3c0f}, 56);
    chk({busy, active}, 34'h3);
    repeat (20) @(negedge clk);
    mem_ready = 1'b1;
    poll();
    chk(wq.size(), 34'h3);
    chk(wq.pop_front(), {3'h0, 23'h0012fe, 8'h5a});
    chk(wq.pop_front(), {3'h0, 23'h0012ff, 8'h3c});
    chk(wq.pop_front(), {3'h0, 23'h001200, 8'h0f});
    st(8'h00);
    $display("test program done");
    // Odd clock count refused, then protection of two top sectors
    write_enable_cmd();
    send({`SFWP_CMD_PAGE_PROGRAM, 24'h000020, 8'h11, 16'h0}, 41);
    chk(busy, 34'h0);
    st(8'h02);
    send({`SFWP_CMD_STATUS_WRITE, 8'h04, 40'h0}, 16);
    poll();
    st(8'h04);
    write_enable_cmd();
    send({`SFWP_CMD_SECTOR_ERASE, 24'h7e0000, 24'h0}, 32);
    chk(busy, 34'h0);
    st(8'h04);
    write_enable_cmd();
    send({`SFWP_CMD_SECTOR_ERASE, 24'h7d1234, 24'h0}, 32);
    poll();
    w = wq.pop_front();
    chk({w[33:24], w[7:0]}, {3'h1, 7'h7d, 8'hff});
    $display("test erase done");
    // Bulk erase gating, frozen protection, boosted bulk erase
    write_enable_cmd();
    send({`SFWP_CMD_BULK_ERASE, 48'h0}, 8);
    chk(busy, 34'h0);
    nwp = 1'b0;
    write_enable_cmd();
    send({`SFWP_CMD_STATUS_WRITE, 8'h00, 40'h0}, 16);
    poll();
    st(8'h04);
    nwp = 1'b1;
    write_enable_cmd();
    send({`SFWP_CMD_STATUS_WRITE, 8'h80, 40'h0}, 16);
    poll();
    chk(lock, 34'h1);
    boost = 1'b1;
    write_enable_cmd();
    send({`SFWP_CMD_BULK_ERASE, 48'h0}, 8);
    poll();
    boost = 1'b0;
    w = wq.pop_front();
    chk({w[33:31], w[7:0]}, {3'h6, 8'hff});
    chk(wq.size(), 34'h0);
    $display("test protect done");
    // Deselect during a pause drops the half-shifted command
    m.set_mode(1'b0);
    m.brk = 4;
    write_enable_cmd();
    m.brk = -1;
    chk(write_enable_latch, 34'h0);
    m.pz = 3;
    write_enable_cmd();
    m.pz = 11;
    st(8'h82);
    m.pz = -1;
    chk(m.hold_oe, 34'h0);
    repeat (20) @(negedge clk);
    chk({active, sdo_oe}, 34'h0);
    $display("test hold done");
    conclude();
  end
endmodule
